// ---- verilog/epc_pkg.sv ----
// Constants for the e-paper command interpreter: command codes, defaults,
// field positions, register offsets and timing figures.
// Assumes a 10 MHz system clock and an 8-bit byte stream from a serial deframer.
package epc_pkg;

  // Command codes seen with data/command select low.
  localparam logic [7:0] CMD_SOFTSTART  = 8'h0C;
  localparam logic [7:0] CMD_SOFT_REINIT = 8'h12;
  localparam logic [7:0] CMD_TEMP_SEL   = 8'h18;
  localparam logic [7:0] CMD_TEMP_WRITE = 8'h1A;
  localparam logic [7:0] CMD_ACTIVATE   = 8'h20;
  localparam logic [7:0] CMD_UPD_CTRL   = 8'h21;
  localparam logic [7:0] CMD_UPD_OPTION = 8'h22;

  // Power-on and soft re-init defaults.
  localparam logic [7:0]  RST_PHASE1   = 8'h8B;
  localparam logic [7:0]  RST_PHASE2   = 8'h9C;
  localparam logic [7:0]  RST_PHASE3   = 8'h96;
  localparam logic [7:0]  RST_DURATION = 8'h0F;
  localparam logic [7:0]  RST_TEMP_SEL = 8'h48;
  localparam logic [11:0] RST_TEMP     = 12'h07FF;
  localparam logic [7:0]  RST_UPD_A    = 8'h00;
  localparam logic [7:0]  RST_UPD_B    = 8'h00;
  localparam logic [7:0]  RST_UPD_OPT  = 8'hFF;

  // Temperature source codes.
  localparam logic [7:0] TSEL_EXTERNAL = 8'h48;
  localparam logic [7:0] TSEL_INTERNAL = 8'h80;

  // Phase byte fields.
  localparam int STR_MSB = 6;
  localparam int STR_LSB = 4;
  localparam int OFF_MSB = 3;
  localparam int OFF_LSB = 0;
  localparam logic [3:0] OFF_MIN_CODE = 4'h4;

  // Plane option codes in each nibble of the first update-control byte.
  localparam logic [3:0] PLANE_NORMAL = 4'h0;
  localparam logic [3:0] PLANE_ZERO   = 4'h4;
  localparam logic [3:0] PLANE_INVERT = 4'h8;
  localparam int SRC_MODE_BIT = 7;

  // Source output bounds for the two source modes.
  localparam logic [7:0] SRC_FULL_FIRST = 8'h00;
  localparam logic [7:0] SRC_FULL_LAST  = 8'hAF;
  localparam logic [7:0] SRC_NARROW_FIRST = 8'h08;
  localparam logic [7:0] SRC_NARROW_LAST  = 8'hA7;

  // Register offsets on the plain register port.
  localparam logic [3:0] REG_PHASE1   = 4'h0;
  localparam logic [3:0] REG_PHASE2   = 4'h1;
  localparam logic [3:0] REG_PHASE3   = 4'h2;
  localparam logic [3:0] REG_DURATION = 4'h3;
  localparam logic [3:0] REG_TEMP_SEL = 4'h4;
  localparam logic [3:0] REG_TEMP_HI  = 4'h5;
  localparam logic [3:0] REG_TEMP_LO  = 4'h6;
  localparam logic [3:0] REG_UPD_A    = 4'h7;
  localparam logic [3:0] REG_UPD_B    = 4'h8;
  localparam logic [3:0] REG_UPD_OPT  = 4'h9;
  localparam logic [3:0] REG_STATUS   = 4'hA;
  localparam logic [3:0] REG_CONTROL  = 4'hB;
  localparam int CTRL_REINIT_BIT   = 0;
  localparam int CTRL_ACTIVATE_BIT = 1;

  // Timing: one duration step is 10 ms at the 10 MHz clock.
  localparam int CLK_FREQ_HZ     = 10_000_000;
  localparam int DUR_STEP_MS     = 10;
  localparam int DUR_STEP_CYCLES = DUR_STEP_MS * (CLK_FREQ_HZ / 1000);
  localparam int REINIT_CYCLES   = 16;

endpackage

// ---- verilog/epc_cmd_set.sv ----
// Command interpreter for the booster, temperature and display update commands.
// Assumes a deframer delivers each byte as a one-cycle strobe with its D/C level,
// and that the update sequencer pulses update_done_in when a sequence ends.
// How it works
// - Booster command stores three phase bytes, defaults 8Bh, 9Ch, 96h.
// - Booster command takes a fourth byte, the duration, default 0Fh.
// - Phase bits six to four give driving strength levels one to eight.
// - Phase bits three to zero give off time; codes below 0100 invalid.
// - Duration byte holds phase three, two, one fields high to low.
// - Duration codes 00 to 11 mean 10, 20, 30, 40 ms.
// - Soft re-init command restores every default except deep sleep.
// - Busy stays high while the soft re-init runs.
// - Soft re-init leaves display RAM untouched.
// - Temperature source byte, 48h external default, 80h internal.
// - Temperature write loads twelve bits, high byte then upper nibble.
// - Activation command starts the update sequence, no parameters.
// - Update control command takes two bytes, both default 00h.
// - First byte upper nibble picks red plane normal, zero or invert.
// - First byte lower nibble picks black-white plane the same way.
// - Second byte bit seven narrows sources to outputs 8 to 167.
// - Activation runs the stages enabled in the option byte, default FFh.
`timescale 1ns/1ps

module epc_cmd_set #(
  parameter int DUR_STEP_CYCLES = epc_pkg::DUR_STEP_CYCLES,
  parameter int REINIT_CYCLES   = epc_pkg::REINIT_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Byte stream from the serial deframer.
  input  wire logic        byte_valid_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        dc_in,
  // Register port.
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // Update sequencer handshake.
  input  wire logic        update_done_in,
  output logic             update_start_out,
  output logic      [7:0]  update_option_out,
  output logic             busy_out,
  output logic             soft_reinit_out,
  // Booster soft-start settings, index 0 is phase one.
  output logic [2:0][3:0]  boost_level_out,
  output logic [2:0][3:0]  gate_off_code_out,
  output logic [2:0][7:0]  gate_off_tenths_out,
  output logic [2:0]       gate_off_valid_out,
  output logic [2:0][1:0]  phase_dur_code_out,
  output logic [2:0][21:0] phase_dur_cycles_out,
  // Temperature settings.
  output logic             temp_internal_out,
  output logic      [11:0] temp_out,
  // Display update RAM and source options.
  output logic      [1:0]  red_plane_mode_out,
  output logic      [1:0]  black_white_plane_mode_out,
  output logic      [7:0]  src_first_out,
  output logic      [7:0]  src_last_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and state.

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REINIT,
    ST_UPDATE
  } epc_fsm_type;

  // Plane modes on the output: 0 normal, 1 forced to zero, 2 inverted.
  typedef enum logic [1:0] {
    PM_NORMAL,
    PM_ZERO,
    PM_INVERT
  } epc_plane_type;

  typedef struct packed {
    logic [2:0][7:0] phase;
    logic [7:0]      duration;
    logic [7:0]      temp_sel;
    logic [11:0]     temp;
    logic [7:0]      upd_a;
    logic [7:0]      upd_b;
    logic [7:0]      upd_opt;
    logic [7:0]      cmd;
    logic [2:0]      idx;
    epc_fsm_type     fsm;
    logic [15:0]     cnt;
    logic            start;
    logic            reinit;
    logic [7:0]      rdata;
  } epc_state_type;

  localparam epc_state_type RESET_STATE = '{
    phase:    {epc_pkg::RST_PHASE3, epc_pkg::RST_PHASE2, epc_pkg::RST_PHASE1},
    duration: epc_pkg::RST_DURATION,
    temp_sel: epc_pkg::RST_TEMP_SEL,
    temp:     epc_pkg::RST_TEMP,
    upd_a:    epc_pkg::RST_UPD_A,
    upd_b:    epc_pkg::RST_UPD_B,
    upd_opt:  epc_pkg::RST_UPD_OPT,
    cmd:      8'h00,
    idx:      3'h0,
    fsm:      ST_IDLE,
    cnt:      16'h0000,
    start:    1'b0,
    reinit:   1'b0,
    rdata:    8'h00
  };

  epc_state_type s_q;
  epc_state_type s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Off time in tenths of a time unit; zero marks a code that is not usable.
  function automatic logic [7:0] off_tenths(input logic [3:0] code);
    logic [7:0] t;
    t = 8'h00;
    unique case (code)
      4'h4: t = 8'd26;
      4'h5: t = 8'd32;
      4'h6: t = 8'd39;
      4'h7: t = 8'd46;
      4'h8: t = 8'd54;
      4'h9: t = 8'd63;
      4'hA: t = 8'd73;
      4'hB: t = 8'd84;
      4'hC: t = 8'd98;
      4'hD: t = 8'd115;
      4'hE: t = 8'd138;
      4'hF: t = 8'd165;
      default: t = 8'h00;
    endcase
    return t;
  endfunction

  // Unknown nibbles fall back to normal so a stray code never blanks the panel.
  function automatic logic [1:0] plane_mode(input logic [3:0] code);
    logic [1:0] m;
    m = PM_NORMAL;
    if (code == epc_pkg::PLANE_ZERO) begin
      m = PM_ZERO;
    end else if (code == epc_pkg::PLANE_INVERT) begin
      m = PM_INVERT;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Bytes that arrive while busy are dropped; the host is expected to wait.
  always_comb begin
    s_d        = s_q;
    s_d.start  = 1'b0;
    s_d.reinit = 1'b0;
    s_d.rdata  = 8'h00;

    // Busy phases: re-init runs a fixed count, an update waits for the sequencer.
    unique case (s_q.fsm)
      ST_IDLE: begin
      end
      ST_REINIT: begin
        if (s_q.cnt <= 16'h0001) begin
          s_d.fsm = ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      ST_UPDATE: begin
        if (update_done_in) begin
          s_d.fsm = ST_IDLE;
        end
      end
    endcase

    if (byte_valid_in && s_q.fsm == ST_IDLE) begin
      if (!dc_in) begin
        s_d.cmd = byte_in;
        s_d.idx = 3'h0;
        if (byte_in == epc_pkg::CMD_SOFT_REINIT) begin
          // Only settings return to defaults; no RAM clear is issued.
          s_d          = RESET_STATE;
          s_d.cmd      = byte_in;
          s_d.fsm      = ST_REINIT;
          s_d.cnt      = REINIT_CYCLES[15:0];
          s_d.reinit   = 1'b1;
        end else if (byte_in == epc_pkg::CMD_ACTIVATE) begin
          s_d.start = 1'b1;
          s_d.fsm   = ST_UPDATE;
        end
      end else begin
        if (s_q.idx != 3'h7) begin
          s_d.idx = s_q.idx + 3'h1;
        end
        unique case (s_q.cmd)
          epc_pkg::CMD_SOFTSTART: begin
            if (s_q.idx < 3'h3) begin
              s_d.phase[s_q.idx[1:0]] = byte_in;
            end else if (s_q.idx == 3'h3) begin
              s_d.duration = byte_in;
            end
          end
          epc_pkg::CMD_TEMP_SEL: begin
            if (s_q.idx == 3'h0) begin
              s_d.temp_sel = byte_in;
            end
          end
          epc_pkg::CMD_TEMP_WRITE: begin
            if (s_q.idx == 3'h0) begin
              s_d.temp[11:4] = byte_in;
            end else if (s_q.idx == 3'h1) begin
              s_d.temp[3:0] = byte_in[7:4];
            end
          end
          epc_pkg::CMD_UPD_CTRL: begin
            if (s_q.idx == 3'h0) begin
              s_d.upd_a = byte_in;
            end else if (s_q.idx == 3'h1) begin
              s_d.upd_b = byte_in;
            end
          end
          epc_pkg::CMD_UPD_OPTION: begin
            if (s_q.idx == 3'h0) begin
              s_d.upd_opt = byte_in;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Register writes land after byte handling, so software wins a same-cycle clash.
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        epc_pkg::REG_PHASE1:   s_d.phase[0]       = reg_wdata_in;
        epc_pkg::REG_PHASE2:   s_d.phase[1]       = reg_wdata_in;
        epc_pkg::REG_PHASE3:   s_d.phase[2]       = reg_wdata_in;
        epc_pkg::REG_DURATION: s_d.duration       = reg_wdata_in;
        epc_pkg::REG_TEMP_SEL: s_d.temp_sel       = reg_wdata_in;
        epc_pkg::REG_TEMP_HI:  s_d.temp[11:4]     = reg_wdata_in;
        epc_pkg::REG_TEMP_LO:  s_d.temp[3:0]      = reg_wdata_in[7:4];
        epc_pkg::REG_UPD_A:    s_d.upd_a          = reg_wdata_in;
        epc_pkg::REG_UPD_B:    s_d.upd_b          = reg_wdata_in;
        epc_pkg::REG_UPD_OPT:  s_d.upd_opt        = reg_wdata_in;
        epc_pkg::REG_CONTROL: begin
          if (s_q.fsm == ST_IDLE && reg_wdata_in[epc_pkg::CTRL_REINIT_BIT]) begin
            s_d        = RESET_STATE;
            s_d.fsm    = ST_REINIT;
            s_d.cnt    = REINIT_CYCLES[15:0];
            s_d.reinit = 1'b1;
          end else if (s_q.fsm == ST_IDLE && reg_wdata_in[epc_pkg::CTRL_ACTIVATE_BIT]) begin
            s_d.start = 1'b1;
            s_d.fsm   = ST_UPDATE;
          end
        end
        default: begin
        end
      endcase
    end

    // Read data stands only in the cycle after the strobe; holes read zero.
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        epc_pkg::REG_PHASE1:   s_d.rdata = s_q.phase[0];
        epc_pkg::REG_PHASE2:   s_d.rdata = s_q.phase[1];
        epc_pkg::REG_PHASE3:   s_d.rdata = s_q.phase[2];
        epc_pkg::REG_DURATION: s_d.rdata = s_q.duration;
        epc_pkg::REG_TEMP_SEL: s_d.rdata = s_q.temp_sel;
        epc_pkg::REG_TEMP_HI:  s_d.rdata = s_q.temp[11:4];
        epc_pkg::REG_TEMP_LO:  s_d.rdata = {s_q.temp[3:0], 4'h0};
        epc_pkg::REG_UPD_A:    s_d.rdata = s_q.upd_a;
        epc_pkg::REG_UPD_B:    s_d.rdata = s_q.upd_b;
        epc_pkg::REG_UPD_OPT:  s_d.rdata = s_q.upd_opt;
        epc_pkg::REG_STATUS:   s_d.rdata = {5'h00, s_q.fsm, s_q.fsm != ST_IDLE};
        default:               s_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs decoded from the stored settings.

  assign reg_rdata_out     = s_q.rdata;
  assign update_start_out  = s_q.start;
  assign update_option_out = s_q.upd_opt;
  assign busy_out          = s_q.fsm != ST_IDLE;
  assign soft_reinit_out   = s_q.reinit;

  // Per-phase fields; the duration byte packs phase one in its low bits.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      boost_level_out[p]      = {1'b0, s_q.phase[p][epc_pkg::STR_MSB:epc_pkg::STR_LSB]}
                                + 4'h1;
      gate_off_code_out[p]    = s_q.phase[p][epc_pkg::OFF_MSB:epc_pkg::OFF_LSB];
      gate_off_tenths_out[p]  = off_tenths(gate_off_code_out[p]);
      gate_off_valid_out[p]   = gate_off_code_out[p] >= epc_pkg::OFF_MIN_CODE;
      phase_dur_code_out[p]   = s_q.duration[2*p +: 2];
      phase_dur_cycles_out[p] = 22'((int'(phase_dur_code_out[p]) + 1) * DUR_STEP_CYCLES);
    end
  end

  assign temp_internal_out = s_q.temp_sel == epc_pkg::TSEL_INTERNAL;
  assign temp_out          = s_q.temp;

  assign red_plane_mode_out         = plane_mode(s_q.upd_a[7:4]);
  assign black_white_plane_mode_out = plane_mode(s_q.upd_a[3:0]);
  assign src_first_out = s_q.upd_b[epc_pkg::SRC_MODE_BIT] ? epc_pkg::SRC_NARROW_FIRST
                                                          : epc_pkg::SRC_FULL_FIRST;
  assign src_last_out  = s_q.upd_b[epc_pkg::SRC_MODE_BIT] ? epc_pkg::SRC_NARROW_LAST
                                                          : epc_pkg::SRC_FULL_LAST;

endmodule

// ---- sim/epc_cmd_set_monitor.sv ----
// Concurrent checks on the ports of the command interpreter.
// Assumes the host spaces its bytes one idle cycle apart.
`timescale 1ns/1ps
module epc_cmd_set_monitor #(
  parameter int DUR_STEP_CYCLES = 10
) (
  // Clock, reset and byte stream.
  input wire logic             clk_sys_in,
  input wire logic             rst_n_in,
  input wire logic             byte_valid_in,
  input wire logic [7:0]       byte_in,
  input wire logic             dc_in,
  // Sequencer handshake and status.
  input wire logic             update_done_in,
  input wire logic             update_start_out,
  input wire logic             busy_out,
  input wire logic             soft_reinit_out,
  // Settings.
  input wire logic [2:0][3:0]  boost_level_out,
  input wire logic [2:0][3:0]  gate_off_code_out,
  input wire logic [2:0]       gate_off_valid_out,
  input wire logic [2:0][1:0]  phase_dur_code_out,
  input wire logic [2:0][21:0] phase_dur_cycles_out,
  input wire logic             temp_internal_out,
  input wire logic [11:0]      temp_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] byte_p_q;
  // Last byte, so a check can look at the fields of a byte already taken.
  always_ff @(posedge clk_sys_in) byte_p_q <= byte_in;
  ////////////////////////////////////////////////////////////////////////////////
  sequence cmd_s(logic [7:0] c);
    byte_valid_in && !dc_in && !busy_out && byte_in == c;
  endsequence
  sequence par_s;
    byte_valid_in && dc_in && !busy_out;
  endsequence
  reinit_busy_a: assert property (cmd_s(8'h12) |=> busy_out && soft_reinit_out)
    else $error("no busy after soft re-init");
  reinit_len_a: assert property (soft_reinit_out |-> busy_out [*8])
    else $error("busy dropped early");
  act_start_a: assert property (cmd_s(8'h20) |=> update_start_out && busy_out)
    else $error("activation did not start");
  upd_end_a: assert property (update_start_out ##[1:50] update_done_in |=> !busy_out)
    else $error("busy held after update end");
  phase_one_a: assert property (cmd_s(8'h0C) ##2 par_s |=>
    boost_level_out[0] == {1'b0, byte_p_q[6:4]} + 4'h1 && gate_off_code_out[0] == byte_p_q[3:0])
    else $error("phase one byte not stored");
  off_valid_a: assert property (gate_off_valid_out == {gate_off_code_out[2] >= 4'h4,
    gate_off_code_out[1] >= 4'h4, gate_off_code_out[0] >= 4'h4})
    else $error("off time validity wrong");
  dur_cycles_a: assert property (
    phase_dur_cycles_out[0] == (phase_dur_code_out[0] + 1) * DUR_STEP_CYCLES)
    else $error("phase duration wrong");
  temp_wr_a: assert property (cmd_s(8'h1A) ##2 par_s ##2 par_s |=>
    temp_out == {$past(byte_in, 3), byte_p_q[7:4]})
    else $error("temperature not loaded");
  temp_sel_a: assert property (cmd_s(8'h18) ##2 par_s |=>
    temp_internal_out == (byte_p_q == 8'h80))
    else $error("sensor select wrong");
endmodule
bind epc_cmd_set epc_cmd_set_monitor #(.DUR_STEP_CYCLES(DUR_STEP_CYCLES)) mon_u (.*);

// ---- sim/epc_host_model.sv ----
// Host side of the byte stream, sending command and parameter bytes.
// Assumes one caller at a time.
`timescale 1ns/1ps
module epc_host_model (
  // Clock and device status.
  input  wire logic clk_sys_in,
  input  wire logic busy_in,
  // Byte stream towards the device.
  output logic      byte_valid_out,
  output logic [7:0] byte_out,
  output logic      dc_out
);
  // Idle lines at time zero.
  initial begin
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
    dc_out = 1'b0;
  end
  // One byte a call; the leading edge leaves one idle cycle between bytes.
  task automatic send(input logic is_par, input logic [7:0] v);
    int n;
    n = 0;
    // Busy read at the edge is settled, and the previous byte is always an edge older.
    @(posedge clk_sys_in);
    while (busy_in !== 1'b0 && n < 1000) begin
      @(posedge clk_sys_in);
      n++;
    end
    byte_valid_out <= 1'b1;
    byte_out <= v;
    dc_out <= is_par;
    @(posedge clk_sys_in);
    byte_valid_out <= 1'b0;
    byte_out <= ~v; // Released lines must not echo the last byte.
    dc_out <= ~is_par;
  endtask
endmodule

// ---- sim/epc_cmd_set_tb.sv ----
// Bench for the command interpreter: host model on the byte stream, tasks on
// the register port. Assumes shortened duration and re-init counts.
`timescale 1ns/1ps
module epc_cmd_set_tb;
  logic             clk_sys_in, rst_n_in, bv, dc, rd, wr, done, busy, go, sr, ti;
  logic [7:0]       b, wd, rdat, opt, sf, sl;
  logic [3:0]       ad;
  logic [11:0]      temp;
  logic [1:0]       red, bw;
  logic [2:0][3:0]  lvl, code;
  logic [2:0][7:0]  ten;
  logic [2:0]       ok;
  logic [2:0][1:0]  dcode;
  logic [2:0][21:0] dcyc;
  int               error_cnt = 0;
  int               n_tests = 0;
  int               cyc = 0;
  int               n;
  logic [7:0]       dflt [10] = '{8'h8B, 8'h9C, 8'h96, 8'h0F, 8'h48, 8'h7F, 8'hF0, 8'h00,
                                  8'h00, 8'hFF};
  logic [7:0]       tt [12] = '{8'd26, 8'd32, 8'd39, 8'd46, 8'd54, 8'd63, 8'd73, 8'd84,
                                8'd98, 8'd115, 8'd138, 8'd165};
  epc_cmd_set #(.DUR_STEP_CYCLES(10), .REINIT_CYCLES(12)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .byte_valid_in(bv), .byte_in(b),
    .dc_in(dc), .reg_addr_in(ad), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .update_done_in(done), .update_start_out(go),
    .update_option_out(opt), .busy_out(busy), .soft_reinit_out(sr),
    .boost_level_out(lvl), .gate_off_code_out(code), .gate_off_tenths_out(ten),
    .gate_off_valid_out(ok), .phase_dur_code_out(dcode), .phase_dur_cycles_out(dcyc),
    .temp_internal_out(ti), .temp_out(temp), .red_plane_mode_out(red),
    .black_white_plane_mode_out(bw), .src_first_out(sf), .src_last_out(sl));
  epc_host_model host_u (.clk_sys_in(clk_sys_in), .busy_in(busy), .byte_valid_out(bv),
    .byte_out(b), .dc_out(dc));
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 10 MHz clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Cuts a hang short; the whole run needs far fewer cycles.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One byte through the host, then let the taking edge's updates land.
  task automatic tx(input logic p, input logic [7:0] v);
    host_u.send(p, v);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    rd <= 1'b1;
    ad <= a;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    chk("rdata", rdat, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst_n_in = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    ad = 4'h0;
    wd = 8'h00;
    done = 1'b0;
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 10; i++) rreg(4'(i), dflt[i]);
    chk("lvl", lvl, 12'h221);
    chk("tenths", ten, {8'd39, 8'd98, 8'd84});
    wreg(4'hC, 8'h55);
    rreg(4'hC, 8'h00);
    tx(0, 8'h0C);
    tx(1, 8'h74);
    tx(1, 8'h03);
    tx(1, 8'h5F);
    tx(1, 8'h1B);
    chk("lvl", lvl, 12'h618);
    chk("code", code, 12'hF34);
    chk("tenths", ten, {8'd165, 8'd0, 8'd26});
    chk("valid", ok, 3'b101);
    chk("dcode", dcode, 6'b01_10_11);
    chk("dcyc", dcyc, {22'd20, 22'd30, 22'd40});
    for (int i = 0; i < 16; i++) begin
      wreg(epc_pkg::REG_PHASE1, {1'b0, 3'(i), 4'(i)});
      chk("lvl0", lvl[0], (i % 8) + 1);
      chk("ten0", ten[0], (i < 4) ? 0 : tt[i-4]);
    end
    for (int i = 0; i < 4; i++) begin
      wreg(epc_pkg::REG_DURATION, {2'b00, 2'(i), 2'(i), 2'(i)});
      chk("dcyc2", dcyc[2], (i + 1) * 10);
    end
    tx(0, 8'h18);
    tx(1, 8'h80);
    chk("tsel", ti, 1);
    tx(0, 8'h18);
    tx(1, 8'h48);
    chk("tsel", ti, 0);
    tx(0, 8'h1A);
    tx(1, 8'h12);
    tx(1, 8'h34);
    chk("temp", temp, 12'h123);
    for (int k = 0; k < 3; k++) begin
      tx(0, 8'h21);
      tx(1, {4'(4 * k), 4'(8 - 4 * k)});
      tx(1, (k == 1) ? 8'h80 : 8'h00);
      chk("red", red, k);
      chk("bw", bw, 2 - k);
      chk("first", sf, (k == 1) ? 8 : 0);
      chk("last", sl, (k == 1) ? 167 : 175);
    end
    tx(0, 8'h22);
    tx(1, 8'hC7);
    chk("option", opt, 8'hC7);
    tx(0, 8'h20);
    chk("start", go, 1);
    chk("busy", busy, 1);
    repeat (5) @(posedge clk_sys_in);
    done <= 1'b1;
    @(posedge clk_sys_in);
    done <= 1'b0;
    #1;
    chk("busy", busy, 0);
    tx(0, 8'h12);
    chk("pulse", sr, 1);
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      n++;
      @(posedge clk_sys_in);
      #1;
    end
    chk("reinit len", n, 12);
    chk("temp", temp, 12'h7FF);
    chk("lvl", lvl, 12'h221);
    chk("option", opt, 8'hFF);
    chk("last", sl, 175);
    // Control register: activation, status while updating, then re-init wins over activation when both bits are set.
    wreg(epc_pkg::REG_UPD_A, 8'h48);
    wreg(epc_pkg::REG_CONTROL, 8'h02);
    chk("start", go, 1);
    rreg(epc_pkg::REG_STATUS, 8'h05);
    @(posedge clk_sys_in);
    done <= 1'b1;
    @(posedge clk_sys_in);
    done <= 1'b0;
    wreg(epc_pkg::REG_CONTROL, 8'h03);
    chk("pulse", sr, 1);
    rreg(epc_pkg::REG_STATUS, 8'h03);
    repeat (12) @(posedge clk_sys_in);
    rreg(epc_pkg::REG_UPD_A, 8'h00);
    // Hardware reset while idle restores the option byte default and leaves busy low.
    wreg(epc_pkg::REG_UPD_OPT, 8'h3C);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rreg(epc_pkg::REG_UPD_OPT, 8'hFF);
    chk("busy", busy, 0);
    final_report();
  end
endmodule
